// file: rtl/power_on_reset_startup_sequencer.sv
// Contract
// - hold reset while main supply is low; release after full filter time.
// - set power-on flag in service fault status 1 when self-test completes.
// - any access to service fault status 1 clears the power-on flag; an access in the cycle self-test completes leaves the flag set.
// - set reset pin echo bit on power-on exit, whatever the pin level.
// - internal regulator or bandgap over/under voltage also forces power-on reset.
// - start initialization and self-test when main supply passes threshold.
// - drive fault output low during the whole initialization.
// - release fault output only when init done and reset pin high.
// - registers keep defaults and ignore writes until ready.
// - main supply undervoltage disables solenoid outputs and fail-safe pre-driver.
// - power down needs no ordering between main and battery supplies.
// - battery overvoltage disables outputs until host acknowledges after recovery.
// - high-voltage or cranking excursions recover without host action.
// - battery overvoltage visible as readable status.
// - main supply over and under voltage visible as readable status.
module power_on_reset_startup_sequencer
  import por_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic main_supply_uv,
  input wire logic main_supply_ov,
  input wire logic internal_reg_fault,
  input wire logic battery_ov,
  input wire logic battery_excursion,
  input wire logic ext_reset_n,
  input wire logic selftest_done,
  input wire logic sfs1_access,
  input wire logic bat_ov_ack,
  input wire logic cfg_we,
  input wire logic [CFG_W-1:0] cfg_wdata,
  output logic in_reset,
  output logic selftest_start,
  output logic fault_out_n,
  output logic fault_out_n_oe,
  output logic por_flag,
  output logic reset_pin_echo,
  output logic ready,
  output logic drivers_enable,
  output logic [SUPPLY_STATUS_W-1:0] supply_status,
  output logic [CFG_W-1:0] cfg_q
);
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  seq_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic por_flag_q, por_flag_d;
  logic echo_q, echo_d;
  logic bat_lock_q, bat_lock_d;
  logic [CFG_W-1:0] cfg_d;
  logic [SUPPLY_STATUS_W-1:0] stat_q, stat_d;
  logic start_q, start_d;
  logic pin_hi;
  logic por_cond;

  pin_deglitch u_dg (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin_raw(ext_reset_n),
    .pin_clean(pin_hi)
  );

  assign por_cond = main_supply_uv | internal_reg_fault;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    por_flag_d = por_flag_q;
    echo_d = echo_q;
    start_d = 1'b0;
    if (por_cond) begin
      state_d = ST_RESET;
      cnt_d = '0;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_d = ST_FILTER;
          cnt_d = '0;
        end
        ST_FILTER: begin
          if (cnt_q == CNT_W'(RESET_FILTER_CYCLES - 1)) begin
            state_d = ST_INIT;
            start_d = 1'b1;
          end else begin
            cnt_d = cnt_q + CNT_W'(1);
          end
        end
        ST_INIT: begin
          if (selftest_done) begin
            state_d = ST_WAIT_PIN;
            echo_d = 1'b1;
          end
        end
        ST_WAIT_PIN: begin
          if (pin_hi) begin
            state_d = ST_READY;
          end
        end
        ST_READY: begin
          if (!pin_hi) begin
            state_d = ST_WAIT_PIN;
          end
        end
        default: state_d = ST_RESET;
      endcase
    end
    // access clears, but a set in the same cycle wins
    if (sfs1_access) begin
      por_flag_d = 1'b0;
    end
    if (!por_cond && state_q == ST_INIT && selftest_done) begin
      por_flag_d = 1'b1;
    end
  end

  // ----------------------------------------
  // supply status and output gating
  // ----------------------------------------
  always_comb begin
    stat_d = '0;
    stat_d[ST_BAT_OV] = battery_ov;
    stat_d[ST_MAIN_OV] = main_supply_ov;
    stat_d[ST_MAIN_UV] = main_supply_uv;
    bat_lock_d = bat_lock_q;
    // overvoltage latches until host acknowledges with battery back in range
    if (bat_ov_ack && !battery_ov) begin
      bat_lock_d = 1'b0;
    end
    if (battery_ov) begin
      bat_lock_d = 1'b1;
    end
    cfg_d = cfg_q;
    if (!ready) begin
      cfg_d = CFG_RESET;
    end else if (cfg_we) begin
      cfg_d = cfg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_RESET;
      cnt_q <= '0;
      por_flag_q <= 1'b0;
      echo_q <= 1'b0;
      bat_lock_q <= 1'b0;
      cfg_q <= CFG_RESET;
      stat_q <= '0;
      start_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      por_flag_q <= por_flag_d;
      echo_q <= echo_d;
      bat_lock_q <= bat_lock_d;
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      start_q <= start_d;
    end
  end

  // pin term drops ready in the very cycle the pin is seen low, not one cycle later
  assign ready = (state_q == ST_READY) && pin_hi;
  assign in_reset = (state_q == ST_RESET) || (state_q == ST_FILTER);
  assign selftest_start = start_q;
  assign por_flag = por_flag_q;
  assign reset_pin_echo = echo_q;
  assign supply_status = stat_q;
  // open drain: low is driven, high is released to the pull-up
  assign fault_out_n = 1'b0;
  assign fault_out_n_oe = !ready;
  // excursions other than overvoltage never latch, so they recover alone
  // undervoltage alone suffices, independent of battery level
  assign drivers_enable = ready && !main_supply_uv && !bat_lock_q
                          && !battery_excursion;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_init_done;
    state_q == ST_INIT && selftest_done && !por_cond && ce;
  endsequence

  a_hold_in_reset: assert property (@(posedge clk) disable iff (rst)
    ce && por_cond |=> in_reset) else $error("reset not held on low supply");
  a_filter_len: assert property (@(posedge clk) disable iff (rst)
    $fell(in_reset) |-> $past(cnt_q) == CNT_W'(RESET_FILTER_CYCLES - 1))
    else $error("filter time wrong");
  a_por_flag_set: assert property (@(posedge clk) disable iff (rst)
    s_init_done |=> por_flag) else $error("power-on flag not set");
  a_por_flag_clr: assert property (@(posedge clk) disable iff (rst)
    ce && sfs1_access && !(state_q == ST_INIT && selftest_done) |=> !por_flag)
    else $error("power-on flag not cleared");
  a_echo_set: assert property (@(posedge clk) disable iff (rst)
    s_init_done |=> reset_pin_echo) else $error("echo not set");
  a_fault_low: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_INIT |-> fault_out_n_oe) else $error("fault released in init");
  a_fault_release: assert property (@(posedge clk) disable iff (rst)
    !fault_out_n_oe |-> pin_hi && $past(state_q) != ST_INIT) else $error("early release");
  a_cfg_default: assert property (@(posedge clk) disable iff (rst)
    ce && !ready |=> cfg_q == CFG_RESET) else $error("config changed before ready");
  a_uv_disable: assert property (@(posedge clk) disable iff (rst)
    main_supply_uv |-> !drivers_enable) else $error("drivers on at undervoltage");
  a_bat_ov_lock: assert property (@(posedge clk) disable iff (rst)
    ce && battery_ov ##1 !bat_ov_ack [*2] |-> !drivers_enable)
    else $error("drivers on after overvoltage");
  a_bat_status: assert property (@(posedge clk) disable iff (rst)
    ce |=> supply_status[ST_BAT_OV] == $past(battery_ov)) else $error("status stale");
  a_main_status: assert property (@(posedge clk) disable iff (rst)
    ce |=> supply_status[ST_MAIN_UV] == $past(main_supply_uv)) else $error("uv stale");
  a_main_ov_status: assert property (@(posedge clk) disable iff (rst)
    ce |=> supply_status[ST_MAIN_OV] == $past(main_supply_ov)) else $error("ov stale");
  a_start_pulse: assert property (@(posedge clk) disable iff (rst)
    $fell(in_reset) |-> selftest_start) else $error("self-test not started");
  a_ready_entry: assert property (@(posedge clk) disable iff (rst)
    $rose(ready) |-> pin_hi && $past(state_q) == ST_WAIT_PIN)
    else $error("ready without init and pin");
  a_excursion_no_lock: assert property (@(posedge clk) disable iff (rst)
    ce && battery_excursion && !battery_ov && !bat_lock_q |=> !bat_lock_q)
    else $error("excursion latched the outputs off");
endmodule

// file: inc/por_seq_pkg.sv
package por_seq_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // filter time figures: no value is given, plain defaults
  localparam int RESET_FILTER_TIME_US = 1;
  localparam int RESET_FILTER_CYCLES = (RESET_FILTER_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int EXT_RESET_DEGLITCH_NS = 5000;
  localparam int EXT_RESET_DEGLITCH_CYCLES = EXT_RESET_DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int DG_W = 11;
  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int SUPPLY_STATUS_W = 3;
  localparam int ST_BAT_OV = 0;
  localparam int ST_MAIN_OV = 1;
  localparam int ST_MAIN_UV = 2;
  localparam int CFG_W = 16;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ST_RESET, ST_FILTER, ST_INIT, ST_WAIT_PIN, ST_READY
  } seq_state_t;
endpackage

// file: rtl/pin_deglitch.sv
module pin_deglitch
  import por_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin_raw,
  output logic pin_clean
);
  logic [DG_W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;

  // level must hold steady for the full deglitch window before it is accepted
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (pin_raw == out_q) begin
      cnt_d = '0;
    end else if (cnt_q == DG_W'(EXT_RESET_DEGLITCH_CYCLES - 1)) begin
      cnt_d = '0;
      out_d = pin_raw;
    end else begin
      cnt_d = cnt_q + DG_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign pin_clean = out_q;
endmodule

// file: bench/host_model.sv
module host_model (
  input wire logic clk,
  input wire logic in_reset,
  input wire logic pin_req,
  input wire logic access_req,
  output logic ext_reset_n = 1'b0,
  output logic sfs1_access = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // host side of pin and serial port
  // ----------------------------------------
  // a real host waits out the filter time, so no access while held in reset
  always @(negedge clk) begin
    ext_reset_n <= pin_req;
    sfs1_access <= access_req && !in_reset;
  end
endmodule

// file: bench/power_on_reset_startup_sequencer_tb.sv
module power_on_reset_startup_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import por_seq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic main_supply_uv = 1'b1, main_supply_ov = 1'b0, internal_reg_fault = 1'b0;
  logic battery_ov = 1'b0, battery_excursion = 1'b0, selftest_done = 1'b0;
  logic bat_ov_ack = 1'b0, cfg_we = 1'b0, pin_req = 1'b1, acc_req = 1'b0;
  logic [CFG_W-1:0] cfg_wdata = 16'h0000;
  logic ext_reset_n, sfs1_access, in_reset, selftest_start, fault_out_n, fault_out_n_oe;
  logic por_flag, reset_pin_echo, ready, drivers_enable;
  logic [SUPPLY_STATUS_W-1:0] supply_status;
  logic [CFG_W-1:0] cfg_q;
  int mismatches = 0;
  int samples_checked = 0;

  power_on_reset_startup_sequencer power_on_reset_startup_sequencer_i (
    .clk, .rst, .ce, .main_supply_uv, .main_supply_ov, .internal_reg_fault,
    .battery_ov, .battery_excursion, .ext_reset_n, .selftest_done, .sfs1_access,
    .bat_ov_ack, .cfg_we, .cfg_wdata, .in_reset, .selftest_start, .fault_out_n,
    .fault_out_n_oe, .por_flag, .reset_pin_echo, .ready, .drivers_enable,
    .supply_status, .cfg_q
  );
  host_model host_model_i (
    .clk, .in_reset, .pin_req, .access_req(acc_req), .ext_reset_n, .sfs1_access
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse_ack();
    bat_ov_ack <= 1'b1;
    tick(1);
    bat_ov_ack <= 1'b0;
    tick(3);
  endtask

  // supply good, filter, init, then pin release; pin may already be high
  // exp_oe: whether the fault pin is still held once init is done, which depends
  // on the reset pin having passed its deglitch window before init completes
  task automatic boot(input logic exp_oe);
    int n;
    main_supply_uv <= 1'b0;
    internal_reg_fault <= 1'b0;
    selftest_done <= 1'b0;
    tick(249);
    chk(in_reset, 1'b1);
    chk(fault_out_n, 1'b0);
    chk(fault_out_n_oe, 1'b1);
    n = 0;
    while (selftest_start !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(selftest_start, 1'b1);
    cfg_we <= 1'b1;
    cfg_wdata <= 16'h5A3C;
    tick(1);
    cfg_we <= 1'b0;
    tick(1);
    chk(cfg_q, 16'h0000);
    chk(fault_out_n_oe, 1'b1);
    selftest_done <= 1'b1;
    tick(2);
    chk(por_flag, 1'b1);
    chk(reset_pin_echo, 1'b1);
    chk(fault_out_n_oe, exp_oe);
    pin_req <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 1400) begin
      tick(1);
      n++;
    end
    chk(ready, 1'b1);
    chk(fault_out_n_oe, 1'b0);
    chk(drivers_enable, 1'b1);
  endtask

  task automatic run_ready_checks();
    cfg_we <= 1'b1;
    tick(1);
    cfg_we <= 1'b0;
    tick(2);
    chk(cfg_q, 16'h5A3C);
    ce <= 1'b0;
    cfg_we <= 1'b1;
    cfg_wdata <= 16'h0F0F;
    tick(2);
    ce <= 1'b1;
    cfg_we <= 1'b0;
    tick(1);
    chk(cfg_q, 16'h5A3C);
    acc_req <= 1'b1;
    tick(1);
    acc_req <= 1'b0;
    tick(3);
    chk(por_flag, 1'b0);
    battery_ov <= 1'b1;
    tick(3);
    chk(supply_status[ST_BAT_OV], 1'b1);
    chk(drivers_enable, 1'b0);
    battery_ov <= 1'b0;
    tick(3);
    chk(drivers_enable, 1'b0);
    pulse_ack();
    chk(drivers_enable, 1'b1);
    battery_excursion <= 1'b1;
    tick(3);
    battery_excursion <= 1'b0;
    tick(3);
    chk(drivers_enable, 1'b1);
    main_supply_ov <= 1'b1;
    tick(3);
    chk(supply_status[ST_MAIN_OV], 1'b1);
    main_supply_ov <= 1'b0;
  endtask

  // power down with battery overvoltage at the same moment, then boot with pin low
  task automatic power_down();
    main_supply_uv <= 1'b1;
    battery_ov <= 1'b1;
    pin_req <= 1'b0;
    tick(3);
    chk(drivers_enable, 1'b0);
    chk(in_reset, 1'b1);
    chk(supply_status[ST_MAIN_UV], 1'b1);
    battery_ov <= 1'b0;
    pulse_ack();
    // pin low must outlast the deglitch window, or the block still sees it high
    tick(EXT_RESET_DEGLITCH_CYCLES + 2);
    boot(1'b1);
    internal_reg_fault <= 1'b1;
    tick(3);
    chk(in_reset, 1'b1);
    chk(ready, 1'b0);
    boot(1'b0);
  endtask

  initial begin
    #80000;
    mismatches++;
    print_verdict();
  end

  initial begin
    tick(20);
    rst <= 1'b0;
    boot(1'b1);
    run_ready_checks();
    power_down();
    print_verdict();
  end
endmodule
